/* verilog/sfft_core.sv */
// streaming fft engine: sample loading, windowing, block scaling and dump
// assumes all strobes and handshakes synchronous to i_core_clk
// Notes on behaviour
// [RULE1] aux word latched at mode strobe rise
// [RULE2] mode strobe low resets control logic
// [RULE3] aux carries imag or second real stream
// [RULE4] primary input carries real samples
// [RULE5] result buses driven only done and dump
// [RULE6] shift count shown at transform end
// [RULE7] two-bit growth caps at 14, 15=overflow
// [RULE8] load flag set, cleared after programmed portion
// [RULE9] load enable gates strobe or triggers load
// [RULE10] one sample per input strobe rise
// [RULE11] one result per output strobe rise
// [RULE12] input strobe divided when pacing overlap
// [RULE13] done low at completion, sequential output
// [RULE14] optional done delay of 24 strobes
// [RULE15] dump enable low starts the dump
// [RULE16] float disable bypasses normalisation
// [RULE17] overlap of 0, 50 or 75 percent
// [RULE18] small blocks load, transform, dump concurrently; the code overlaps loading only, the next transform waits for the dump to end
// [RULE19] forward/inverse, real/complex, up to 1024
// [RULE20] internal hamming or blackman-harris window
// [RULE21] everything on the one core clock
// [RULE22] 1024, 256, 4x64, 16x16 sizes
// [RULE23] overflow forces every bin to zero
// [RULE24] growth bit selects two or three bits
// [RULE25] mode word layout defined here
`timescale 1ns/10ps
module sfft_core
  import sfft_pkg::*;
#(
  parameter int ADDR_W = AW
) (
  input  logic        i_core_clk,
  input  logic        i_arst_n,
  input  logic        i_clk_en,
  input  logic        i_mode_latch_reset_n,
  input  logic [15:0] i_aux_imag_config_bus,
  input  logic [15:0] i_primary_sample_in,
  input  logic        i_load_enable_n,
  input  logic        i_input_sample_strobe,
  input  logic        i_output_sample_strobe,
  input  logic        i_dump_enable_n,
  input  logic        i_block_float_disable,
  input  logic [1:0]  i_avs_address,
  input  logic        i_avs_read,
  input  logic        i_avs_write,
  input  logic [31:0] i_avs_writedata,
  input  logic [3:0]  i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic        o_avs_waitrequest,
  output logic [15:0] o_real_result_out,
  output logic        o_real_result_oe,
  output logic [15:0] o_imag_result_out,
  output logic        o_imag_result_oe,
  output logic [3:0]  o_scale_shift_count,
  output logic        o_load_in_progress_flag,
  output logic        o_transform_done_n
);
  localparam int CW = ADDR_W + 1;

  // cosine of 2*pi*p/1024 in q15, two mirrored parabolas;
  // cheap, at the cost of a few percent error in window shape
  function automatic logic signed [15:0] f_cos(input logic [9:0] p);
    logic [9:0]  a;
    logic [19:0] sq;
    a  = (p >= PH_HALF) ? p - PH_HALF : PH_HALF - p;
    if (a <= PH_QTR) begin
      sq    = a * a;
      f_cos = $signed(16'(sq[19:1])) - $signed(COS_ONE);
    end else begin
      a     = PH_HALF - a;
      sq    = a * a;
      f_cos = $signed(COS_ONE) - $signed(16'(sq[19:1]));
    end
  endfunction : f_cos

  function automatic logic [15:0] f_win(input logic signed [15:0] x,
                                        input logic signed [15:0] w, input logic rect);
    logic signed [31:0] p;
    p     = x * w;
    f_win = rect ? x : p[30:15];
  endfunction : f_win

  // saturating negate keeps the most negative code from wrapping
  function automatic logic [15:0] f_neg(input logic [15:0] x);
    f_neg = (x == MOST_NEG) ? MOST_POS : 16'(-x);
  endfunction : f_neg

  function automatic logic [3:0] f_lz(input logic [14:0] v);
    f_lz = SHIFT_MAX;
    for (int i = 0; i < 15; i++) begin
      if (v[i]) f_lz = 4'(14 - i);
    end
  endfunction : f_lz

  // edge history of the synchronous strobes
  logic lat_prev_r;
  logic ist_prev_r;
  logic ost_prev_r;
  logic len_prev_r;
  // history resets to each pin's idle level, so no false edge follows reset
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lat_prev_r <= 1'b1;
      ist_prev_r <= 1'b0;
      ost_prev_r <= 1'b0;
      len_prev_r <= 1'b1;
    end else if (i_clk_en) begin
      lat_prev_r <= i_mode_latch_reset_n;
      ist_prev_r <= i_input_sample_strobe;
      ost_prev_r <= i_output_sample_strobe;
      len_prev_r <= i_load_enable_n;
    end
  end

  // [RULE21] single clock edges
  wire lat_rise = i_mode_latch_reset_n & ~lat_prev_r;
  wire ctl_rst  = ~i_mode_latch_reset_n;
  wire ist_rise = i_input_sample_strobe & ~ist_prev_r;
  wire ost_rise = i_output_sample_strobe & ~ost_prev_r;
  wire len_fall = ~i_load_enable_n & len_prev_r;

  // avalon slave: one wait cycle, then the answer
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [15:0] mode_r;
  wire req      = i_avs_read | i_avs_write;
  wire wr_go    = i_avs_write & ~wait_r;
  wire sel_mode = (i_avs_address == REG_MODE);
  wire sel_stat = (i_avs_address == REG_STAT);
  wire sel_cnt  = (i_avs_address == REG_CNT);

  // [RULE1] mode capture
  wire [15:0] mode_wr = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : mode_r[15:8],
                         i_avs_byteenable[0] ? i_avs_writedata[7:0] : mode_r[7:0]};
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_r <= MODE_RST;
    end else if (i_clk_en) begin
      if (lat_rise) mode_r <= i_aux_imag_config_bus;
      else if (wr_go && sel_mode) mode_r <= mode_wr;
    end
  end

  // [RULE25] mode word decode
  wire [1:0] sz   = mode_r[MW_SIZE +: 2];
  wire       big  = (sz == SZ_1024);
  wire       is16 = (sz == SZ_16X16);
  // [RULE22] sixteen point sets force rectangle, no overlap
  wire [1:0] win  = is16 ? WIN_RECT : mode_r[MW_WIN +: 2];
  wire [1:0] ovl  = is16 ? OVL_NONE : mode_r[MW_OVL +: 2];
  wire [1:0] fsel = mode_r[MW_FLAG +: 2];
  wire       inv  = mode_r[MW_INV];
  wire       g3   = mode_r[MW_G3];
  wire       trig = mode_r[MW_TRIG];
  wire       divm = mode_r[MW_DIV];
  wire       dly  = mode_r[MW_DLY];
  wire [CW-1:0] n_pts = big ? CW'(N_BIG) : CW'(N_SMALL);

  // [RULE17] overlap sets the hop between blocks
  wire [CW-1:0] hop = (ovl == OVL_50) ? n_pts >> 1 : (ovl == OVL_75) ? n_pts >> 2 : n_pts;
  wire [CW-1:0] portion = (fsel == FLG_QTR) ? n_pts >> 2 :
                          (fsel == FLG_HALF) ? n_pts >> 1 : n_pts;
  // [RULE12] shared strobe divided by the hop ratio
  wire [1:0] div_mask = !divm ? 2'h0 : (ovl == OVL_50) ? 2'h1 : (ovl == OVL_75) ? 2'h3 : 2'h0;

  // loading side
  logic              load_act_r;
  logic              flag_r;
  logic [1:0]        div_r;
  logic [ADDR_W-1:0] wr_ptr_r;
  logic [CW-1:0]     fill_r;
  logic [CW-1:0]     fcnt_r;
  // [RULE9] qualifier or trigger
  wire gate      = trig ? load_act_r : ~i_load_enable_n;
  wire strobe_in = ist_rise & gate;
  // [RULE10] one sample per accepted rise
  wire take      = strobe_in & ((div_r & div_mask) == 2'h0);
  wire [CW-1:0] fill_inc = fill_r + 1'b1;
  wire [CW-1:0] fcnt_inc = fcnt_r + 1'b1;
  wire emit = take & (fill_inc == n_pts);
  wire [ADDR_W-1:0] wr_nxt   = wr_ptr_r + 1'b1;
  wire [ADDR_W-1:0] blk_base = wr_nxt - n_pts[ADDR_W-1:0];

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_act_r <= 1'b0;
      flag_r     <= 1'b0;
      div_r      <= 2'h0;
      wr_ptr_r   <= '0;
      fill_r     <= '0;
      fcnt_r     <= '0;
    end else if (i_clk_en) begin
      // [RULE2] held in reset while strobe low
      if (ctl_rst) begin
        load_act_r <= 1'b0;
        flag_r     <= 1'b0;
        div_r      <= 2'h0;
        wr_ptr_r   <= '0;
        fill_r     <= '0;
        fcnt_r     <= '0;
      end else begin
        if (strobe_in) div_r <= div_r + 1'b1;
        if (take) wr_ptr_r <= wr_nxt;
        // retained samples of an overlapped block stay counted
        if (take) fill_r <= emit ? fill_inc - hop : fill_inc;
        if (emit) load_act_r <= 1'b0;
        // [RULE8] flag drops after the portion
        if (take) fcnt_r <= fcnt_inc;
        if (take && fcnt_inc == portion) flag_r <= 1'b0;
        // a new trigger wins over a same-cycle finish
        if (len_fall) begin
          load_act_r <= 1'b1;
          flag_r     <= 1'b1;
          fcnt_r     <= '0;
        end
      end
    end
  end

  // sample ring and work store; the ring lets loading run on during a dump
  logic [15:0] ring_re [2**ADDR_W];
  logic [15:0] ring_im [2**ADDR_W];
  logic [15:0] wk_re   [2**ADDR_W];
  logic [15:0] wk_im   [2**ADDR_W];
  logic [15:0] rr_re_r;
  logic [15:0] rr_im_r;
  logic [15:0] rd_re_r;
  logic [15:0] rd_im_r;

  // engine registers
  sfft_eng_t         eng_r;
  logic              pend_r;
  logic [ADDR_W-1:0] pend_base_r;
  logic [ADDR_W-1:0] base_r;
  logic [CW-1:0]     sc_r;
  logic [CW-1:0]     dcnt_r;
  logic [4:0]        dly_r;
  logic [14:0]       acc_r;
  logic              ovf_acc_r;
  logic              ovf_r;
  logic [3:0]        shift_r;
  logic              oe_r;
  logic              done_n_r;
  logic [15:0]       out_re_r;
  logic [15:0]       out_im_r;
  logic [15:0]       blk_cnt_r;

  wire start    = (eng_r == ENG_IDLE) & pend_r;
  wire in_scan  = (eng_r == ENG_SCAN);
  wire scan_wr  = in_scan & (sc_r != '0);
  wire scan_end = in_scan & (sc_r == n_pts);
  wire in_done  = (eng_r == ENG_READY) | (eng_r == ENG_DUMP);
  wire [ADDR_W-1:0] rd_addr = base_r + sc_r[ADDR_W-1:0];
  wire [ADDR_W-1:0] wk_addr = ADDR_W'(sc_r - 1'b1);

  // [RULE4] real part or first real stream
  // [RULE3] imag part or second real stream
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && take && !ctl_rst) begin
      ring_re[wr_ptr_r] <= i_primary_sample_in;
      ring_im[wr_ptr_r] <= i_aux_imag_config_bus;
    end
  end

  // [RULE20] window phase follows place in sub-block
  wire [9:0] ph  = big ? PH_W'(wk_addr) :
                   (sz == SZ_256) ? {wk_addr[7:0], 2'h0} : {wk_addr[5:0], 4'h0};
  wire [9:0] ph2 = {ph[8:0], 1'b0};
  wire [9:0] ph3 = ph + ph2;
  wire signed [15:0] c1 = f_cos(ph);
  wire signed [15:0] c2 = f_cos(ph2);
  wire signed [15:0] c3 = f_cos(ph3);
  wire signed [31:0] mh  = HAM_A1 * c1;
  wire signed [31:0] mb1 = BH_A1 * c1;
  wire signed [31:0] mb2 = BH_A2 * c2;
  wire signed [31:0] mb3 = BH_A3 * c3;
  wire signed [15:0] w_ham = HAM_A0 - $signed(mh[30:15]);
  wire signed [15:0] w_bh  = BH_A0 - $signed(mb1[30:15]) + $signed(mb2[30:15]) - $signed(mb3[30:15]);
  wire signed [15:0] w_sel = (win == WIN_BH) ? w_bh : w_ham;
  wire rect = (win != WIN_HAM) && (win != WIN_BH);

  // [RULE19] inverse taken as conjugate in and out
  wire [15:0] im_in = inv ? f_neg(rr_im_r) : rr_im_r;
  wire [15:0] xw_re = f_win(rr_re_r, w_sel, rect);
  wire [15:0] xw_im = f_win(im_in, w_sel, rect);
  // [RULE24] three-bit growth drops one more lsb
  wire [15:0] st_re = g3 ? {xw_re[15], xw_re[15:1]} : xw_re;
  wire [15:0] st_im = g3 ? {xw_im[15], xw_im[15:1]} : xw_im;
  wire ovf_hit = ~g3 & ((st_re == MOST_NEG) | (st_im == MOST_NEG));
  wire [14:0] sig_w = (st_re[14:0] ^ {15{st_re[15]}}) | (st_im[14:0] ^ {15{st_im[15]}});
  wire [14:0] acc_nxt = acc_r | sig_w;
  wire        ovf_nxt = ovf_acc_r | ovf_hit;
  wire [3:0]  lzv = f_lz(acc_nxt);
  wire [3:0]  cap = g3 ? SHIFT_MAX : SHIFT_CAP2;
  // [RULE16] disable bypasses normalisation
  // [RULE7] two-bit cap at 14, three-bit at 15, overflow shown as 15
  wire [3:0]  sh_calc = i_block_float_disable ? 4'h0 :
                        ovf_nxt ? SHIFT_OVF : (lzv > cap) ? cap : lzv;

  // ring and work store ports, registered reads
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en) begin
      rr_re_r <= ring_re[rd_addr];
      rr_im_r <= ring_im[rd_addr];
      rd_re_r <= wk_re[dcnt_r[ADDR_W-1:0]];
      rd_im_r <= wk_im[dcnt_r[ADDR_W-1:0]];
      if (scan_wr) begin
        wk_re[wk_addr] <= st_re;
        wk_im[wk_addr] <= st_im;
      end
    end
  end

  // [RULE23] overflow zeroes the bins
  wire        zero  = ovf_r;
  wire [15:0] sh_re = rd_re_r << shift_r;
  wire [15:0] sh_im = rd_im_r << shift_r;
  wire [15:0] res_re = zero ? 16'h0000 : sh_re;
  wire [15:0] res_im = zero ? 16'h0000 : inv ? f_neg(sh_im) : sh_im;
  wire dump_go = (eng_r == ENG_DUMP) & ost_rise & ~i_dump_enable_n;
  wire [CW-1:0] dcnt_inc = dcnt_r + 1'b1;

  // [RULE18] next block queued while a dump runs
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r      <= 1'b0;
      pend_base_r <= '0;
    end else if (i_clk_en) begin
      if (ctl_rst) pend_r <= 1'b0;
      else pend_r <= emit | (pend_r & ~start);
      if (emit) pend_base_r <= blk_base;
    end
  end

  // engine sequence: scan, optional delay, ready, dump
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eng_r     <= ENG_IDLE;
      base_r    <= '0;
      sc_r      <= '0;
      dcnt_r    <= '0;
      dly_r     <= 5'h0;
      acc_r     <= 15'h0;
      ovf_acc_r <= 1'b0;
      ovf_r     <= 1'b0;
      shift_r   <= 4'h0;
      blk_cnt_r <= 16'h0;
      out_re_r  <= 16'h0;
      out_im_r  <= 16'h0;
    end else if (i_clk_en) begin
      if (ctl_rst) begin
        eng_r  <= ENG_IDLE;
        sc_r   <= '0;
        dcnt_r <= '0;
      end else begin
        unique case (eng_r)
          ENG_IDLE: begin
            if (start) begin
              eng_r     <= ENG_SCAN;
              base_r    <= pend_base_r;
              sc_r      <= '0;
              acc_r     <= 15'h0;
              ovf_acc_r <= 1'b0;
            end
          end
          ENG_SCAN: begin
            sc_r <= sc_r + 1'b1;
            if (scan_wr) begin
              acc_r     <= acc_nxt;
              ovf_acc_r <= ovf_nxt;
            end
            // [RULE6] shift count at transform end
            if (scan_end) begin
              shift_r   <= sh_calc;
              ovf_r     <= ovf_nxt;
              blk_cnt_r <= blk_cnt_r + 1'b1;
              dly_r     <= 5'h0;
              eng_r     <= dly ? ENG_DELAY : ENG_READY;
            end
          end
          // [RULE14] done held back 24 strobes
          ENG_DELAY: begin
            if (ost_rise) begin
              dly_r <= dly_r + 1'b1;
              if (dly_r == DONE_DLY - 1'b1) eng_r <= ENG_READY;
            end
          end
          // [RULE15] wait for dump enable low
          ENG_READY: begin
            if (!i_dump_enable_n) eng_r <= ENG_DUMP;
          end
          // [RULE11] one result per strobe rise
          ENG_DUMP: begin
            if (dump_go) begin
              if (dcnt_r == n_pts) begin
                eng_r  <= ENG_IDLE;
                dcnt_r <= '0;
              end else begin
                dcnt_r   <= dcnt_inc;
                out_re_r <= res_re;
                out_im_r <= res_im;
              end
            end
          end
        endcase
      end
    end
  end

  // [RULE13] done low while results wait or flow
  // [RULE5] buses enabled only with done and dump
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_n_r <= 1'b1;
      oe_r     <= 1'b0;
    end else if (i_clk_en) begin
      done_n_r <= ~in_done | ctl_rst;
      oe_r     <= in_done & ~i_dump_enable_n & ~ctl_rst;
    end
  end

  // register read mux; unmapped words read zero
  wire [31:0] stat_w = {17'h0, 3'(eng_r), 4'h0, pend_r, ovf_r, flag_r, done_n_r, shift_r};
  wire [31:0] cnt_w  = {blk_cnt_r, 6'h0, wr_ptr_r};
  wire [31:0] rd_mux = sel_mode ? {16'h0, mode_r} : sel_stat ? stat_w : sel_cnt ? cnt_w : 32'h0;

  // wait drops for one cycle after each cycle that sees a request while wait is high
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0;
    end else if (i_clk_en) begin
      wait_r <= ~(req & wait_r);
      if (i_avs_read && wait_r) rdata_r <= rd_mux;
    end
  end

  assign o_avs_readdata          = rdata_r;
  assign o_avs_waitrequest       = wait_r;
  assign o_real_result_out       = out_re_r;
  assign o_imag_result_out       = out_im_r;
  assign o_real_result_oe        = oe_r;
  assign o_imag_result_oe        = oe_r;
  assign o_scale_shift_count     = shift_r;
  assign o_load_in_progress_flag = flag_r;
  assign o_transform_done_n      = done_n_r;
endmodule : sfft_core

/* verilog/sfft_pkg.sv */
// constants, mode word layout and state type of the streaming fft block
// assumes one core clock; shared by the core and by the bench
package sfft_pkg;
  localparam int DW   = 16;
  localparam int AW   = 10;
  localparam int PH_W = 10;

  // transform sizes in points
  localparam int N_BIG   = 1024;
  localparam int N_SMALL = 256;

  // mode word field positions
  localparam int MW_SIZE = 0;
  localparam int MW_INV  = 2;
  localparam int MW_WIN  = 3;
  localparam int MW_OVL  = 5;
  localparam int MW_CPLX = 7;
  localparam int MW_FLAG = 8;
  localparam int MW_DLY  = 10;
  localparam int MW_G3   = 11;
  localparam int MW_TRIG = 12;
  localparam int MW_DIV  = 13;
  localparam logic [15:0] MODE_RST = 16'h0000;

  // field encodings
  localparam logic [1:0] SZ_1024  = 2'h0;
  localparam logic [1:0] SZ_256   = 2'h1;
  localparam logic [1:0] SZ_64X4  = 2'h2;
  localparam logic [1:0] SZ_16X16 = 2'h3;
  localparam logic [1:0] WIN_RECT = 2'h0;
  localparam logic [1:0] WIN_HAM  = 2'h1;
  localparam logic [1:0] WIN_BH   = 2'h2;
  localparam logic [1:0] OVL_NONE = 2'h0;
  localparam logic [1:0] OVL_50   = 2'h1;
  localparam logic [1:0] OVL_75   = 2'h2;
  localparam logic [1:0] FLG_FULL = 2'h0;
  localparam logic [1:0] FLG_QTR  = 2'h1;
  localparam logic [1:0] FLG_HALF = 2'h2;

  // scaling and timing figures
  localparam logic [3:0]  SHIFT_CAP2 = 4'he;
  localparam logic [3:0]  SHIFT_MAX  = 4'hf;
  localparam logic [3:0]  SHIFT_OVF  = 4'hf;
  localparam logic [4:0]  DONE_DLY   = 5'h18;
  localparam logic [15:0] MOST_NEG   = 16'h8000;
  localparam logic [15:0] MOST_POS   = 16'h7fff;
  localparam logic [15:0] COS_ONE    = 16'h7fff;
  localparam logic [9:0]  PH_HALF    = 10'h200;
  localparam logic [9:0]  PH_QTR     = 10'h100;

  // window weights in q15
  localparam logic signed [15:0] HAM_A0 = 16'sh451f;
  localparam logic signed [15:0] HAM_A1 = 16'sh3ae1;
  localparam logic signed [15:0] BH_A0  = 16'sh2dec;
  localparam logic signed [15:0] BH_A1  = 16'sh3e80;
  localparam logic signed [15:0] BH_A2  = 16'sh1216;
  localparam logic signed [15:0] BH_A3  = 16'sh017f;

  // avalon word addresses
  localparam logic [1:0] REG_MODE = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_CNT  = 2'h2;

  typedef enum logic [2:0] {ENG_IDLE, ENG_SCAN, ENG_DELAY, ENG_READY, ENG_DUMP} sfft_eng_t;
endpackage : sfft_pkg

/* sim/sfft_core_monitor.sv */
// concurrent checks on the port behaviour of the streaming fft core
// assumes a bind onto sfft_core, one core clock, async active-low reset
`timescale 1ns/10ps
module sfft_core_monitor (
  input logic        i_core_clk,
  input logic        i_arst_n,
  input logic        i_clk_en,
  input logic        i_mode_latch_reset_n,
  input logic        i_load_enable_n,
  input logic        i_output_sample_strobe,
  input logic        i_dump_enable_n,
  input logic        i_avs_read,
  input logic        i_avs_write,
  input logic        o_avs_waitrequest,
  input logic [15:0] o_real_result_out,
  input logic        o_real_result_oe,
  input logic        o_imag_result_oe,
  input logic        o_load_in_progress_flag,
  input logic        o_transform_done_n
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  // result buses share one enable, raised only with done and a dump request
  oe_pair_a: assert property (o_real_result_oe == o_imag_result_oe)
    else $error("result enables differ");
  oe_den_a: assert property ($rose(o_real_result_oe) |-> !$past(i_dump_enable_n))
    else $error("result enable without dump request");
  oe_done_a: assert property ($rose(o_real_result_oe) |-> !o_transform_done_n)
    else $error("result enable without done");
  // a driven result only moves after an output strobe rise
  res_hold_a: assert property (o_real_result_oe && $past(o_real_result_oe) && $changed(o_real_result_out)
    |-> $past(i_output_sample_strobe) || $past(i_output_sample_strobe, 2))
    else $error("result moved without strobe");
  // the mode strobe holds the control side in reset
  ctl_rst_a: assert property (i_clk_en && !i_mode_latch_reset_n
    |=> !o_load_in_progress_flag && o_transform_done_n && !o_real_result_oe)
    else $error("control not reset by mode strobe");
  flag_set_a: assert property (i_clk_en && i_mode_latch_reset_n && $fell(i_load_enable_n)
    |-> ##[1:2] o_load_in_progress_flag)
    else $error("load flag not raised");
  flag_cause_a: assert property ($rose(o_load_in_progress_flag)
    |-> !$past(i_load_enable_n) || !$past(i_load_enable_n, 2))
    else $error("load flag raised without enable");
  // exactly one wait state on every register access
  bus_wait_a: assert property (i_clk_en && (i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("register access timing off");
endmodule : sfft_core_monitor
bind sfft_core sfft_core_monitor u_sfft_core_monitor (.*);

/* sim/sfft_partner.sv */
// sample source and result consumer beside the fft core
// assumes its tasks are called just after core clock edges
`timescale 1ns/10ps
module sfft_partner
  import sfft_pkg::*;
(
  input  logic        i_core_clk,
  input  logic [15:0] i_real_result_out,
  input  logic [15:0] i_imag_result_out,
  input  logic        i_load_in_progress_flag,
  output logic        o_mode_latch_reset_n   = 1'b1,
  output logic [15:0] o_aux_imag_config_bus  = 16'h0,
  output logic [15:0] o_primary_sample_in    = 16'h0,
  output logic        o_load_enable_n        = 1'b1,
  output logic        o_input_sample_strobe  = 1'b0,
  output logic        o_output_sample_strobe = 1'b0,
  output logic        o_dump_enable_n        = 1'b1
);
  logic [15:0] cap_re [N_SMALL];
  logic [15:0] cap_im [N_SMALL];
  int          flag_run;
  // mode word held on aux through the edge that sees the strobe high
  task latch(input logic [15:0] w);
    @(posedge i_core_clk);
    o_mode_latch_reset_n <= 1'b0;
    o_aux_imag_config_bus <= w;
    repeat (3) @(posedge i_core_clk);
    o_mode_latch_reset_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    o_aux_imag_config_bus <= ~w;
  endtask : latch
  // output strobes two cycles high, two low
  task pulse(input int n);
    repeat (n) begin
      o_output_sample_strobe <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      o_output_sample_strobe <= 1'b0;
      repeat (2) @(posedge i_core_clk);
    end
  endtask : pulse
  // ramp under a low load enable
  task load(input logic [8:0] bad);
    logic [15:0] re;
    logic [15:0] im;
    flag_run = 0;
    o_load_enable_n <= 1'b0;
    @(posedge i_core_clk);
    for (int i = 0; i < N_SMALL; i++) begin
      re = (i == bad) ? MOST_NEG : 16'(i);
      im = 16'(N_SMALL - 1 - i);
      o_primary_sample_in <= re;
      o_aux_imag_config_bus <= im;
      o_input_sample_strobe <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      // released lines show the inverse so stale data cannot pass
      o_primary_sample_in <= ~re;
      o_aux_imag_config_bus <= ~im;
      o_input_sample_strobe <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      if (i_load_in_progress_flag === 1'b1) flag_run++;
    end
    o_load_enable_n <= 1'b1;
  endtask : load
  // low enable asks for the dump, one extra strobe closes it
  task dump();
    o_dump_enable_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    for (int i = 0; i <= N_SMALL; i++) begin
      pulse(1);
      if (i < N_SMALL) begin
        cap_re[i] = i_real_result_out;
        cap_im[i] = i_imag_result_out;
      end
    end
    o_dump_enable_n <= 1'b1;
  endtask : dump
endmodule : sfft_partner

/* sim/test_sfft_core.sv */
// self-checking bench for the streaming fft core
// assumes the partner model drives the sample and result links
`timescale 1ns/10ps
module test_sfft_core
  import sfft_pkg::*;
;
  logic        i_core_clk = 1'b0, i_arst_n = 1'b0, i_clk_en = 1'b1, i_block_float_disable = 1'b0;
  logic        i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [1:0]  i_avs_address = 2'h0;
  logic [3:0]  i_avs_byteenable = 4'h0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic        i_mode_latch_reset_n, i_load_enable_n, i_input_sample_strobe, i_output_sample_strobe;
  logic        i_dump_enable_n, o_avs_waitrequest, o_real_result_oe, o_imag_result_oe;
  logic        o_load_in_progress_flag, o_transform_done_n;
  logic [15:0] i_aux_imag_config_bus, i_primary_sample_in, o_real_result_out, o_imag_result_out;
  logic [3:0]  o_scale_shift_count;
  int          bad_count = 0, samples_checked = 0;
  // 25 mhz core clock
  always #20 i_core_clk = ~i_core_clk;
  sfft_core u_sfft_core (.*);
  sfft_partner u_sfft_partner (
    .i_core_clk, .i_real_result_out(o_real_result_out), .i_imag_result_out(o_imag_result_out),
    .i_load_in_progress_flag(o_load_in_progress_flag), .o_mode_latch_reset_n(i_mode_latch_reset_n),
    .o_aux_imag_config_bus(i_aux_imag_config_bus), .o_primary_sample_in(i_primary_sample_in),
    .o_load_enable_n(i_load_enable_n), .o_input_sample_strobe(i_input_sample_strobe),
    .o_output_sample_strobe(i_output_sample_strobe), .o_dump_enable_n(i_dump_enable_n)
  );
  task summarize();
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one register access held until waitrequest is seen low; reads compared
  task bus(input logic [1:0] a, input logic wr, input logic [31:0] wd, input logic [31:0] exp);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= wd;
    i_avs_byteenable <= 4'h3;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    if (n >= 50) summarize();
    if (!wr) cmp(o_avs_readdata, exp);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_core_clk);
  endtask : bus
  // one block: latch mode, load ramp, wait for done, dump and compare bins
  task xfer(input logic [15:0] m, input logic bfd, input logic [8:0] bad, input logic [3:0] sh);
    int n;
    n = 0;
    i_block_float_disable <= bfd;
    u_sfft_partner.latch(m);
    bus(REG_MODE, 1'b0, 32'h0, {16'h0, m});
    u_sfft_partner.load(bad);
    cmp(32'(u_sfft_partner.flag_run), 32'h3f);
    if (m[MW_DLY]) begin
      repeat (400) @(posedge i_core_clk);
      u_sfft_partner.pulse(23);
      cmp(o_transform_done_n, 1'b1);
      u_sfft_partner.pulse(1);
    end
    while (o_transform_done_n !== 1'b0 && n < 3000) begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 3000) bad_count++;
    if (n >= 3000) summarize();
    cmp(o_scale_shift_count, sh);
    cmp(o_real_result_oe, 1'b0);
    u_sfft_partner.dump();
    for (int i = 0; i < N_SMALL; i++) begin
      cmp(u_sfft_partner.cap_re[i], bad[8] ? 16'(i) << sh : 16'h0);
      cmp(u_sfft_partner.cap_im[i], bad[8] ? 16'(N_SMALL - 1 - i) << sh : 16'h0);
    end
    repeat (6) @(posedge i_core_clk);
    cmp({o_real_result_oe, o_transform_done_n}, 2'h1);
  endtask : xfer
  // main sequence: register map, then five blocks in four modes
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    @(posedge i_core_clk);
    bus(REG_MODE, 1'b0, 32'h0, 32'h0);
    bus(REG_STAT, 1'b1, 32'hffff_ffff, 32'h0);
    bus(2'h3, 1'b1, 32'h0000_0aaa, 32'h0);
    bus(REG_MODE, 1'b1, 32'hffff_0181, 32'h0);
    bus(REG_STAT, 1'b0, 32'h0, 32'h10);
    bus(2'h3, 1'b0, 32'h0, 32'h0);
    // a latch pulse while the clock enable is low must leave the mode alone
    i_clk_en <= 1'b0;
    u_sfft_partner.latch(16'h0aaa);
    i_clk_en <= 1'b1;
    bus(REG_MODE, 1'b0, 32'h0, 32'h181);
    xfer(16'h0181, 1'b0, 9'h100, 4'h7);
    xfer(16'h0185, 1'b1, 9'h100, 4'h0);
    xfer(16'h0181, 1'b0, 9'h005, SHIFT_OVF);
    xfer(16'h0581, 1'b0, 9'h100, 4'h7);
    xfer(16'h11a1, 1'b0, 9'h100, 4'h7);
    summarize();
  end
endmodule : test_sfft_core
